// >>> rtl/rsew_consts.svh
// Constants for the rasteriser edge walker: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and the design module.
// ============================================================
// Notes on behaviour
// - Sustain at least one fragment every two clock cycles.
// - Line: start copies start coordinate, then one diagonal step per pass.
// - Aliased trapezoid: counter holds scanlines; lead/trail X per scanline.
// - Equal integer lead/trail X: no fragment, passive lead-edge step.
// - Rightmost aliased fragment is never active; passive step may replace it.
// - Host reloads trail edge and count; continue resumes scanline loop.
// - Antialiased: four sub-scanlines per row, X stepped and count per sub.
// - Track extreme lead and trail X per fill direction while loading.
// - Antialiased fill visits lead to trail X inclusive, summing coverage.
// - Active across steps, last is lead-edge step; coverage follows each.
// - Zero coverage gives a passive step instead of an active fragment.
// - Knee inside a row defers filling until the new trail edge loads.
// - Flush message fills the pending partial row.
// - Y walker does start, step or hold each clock; outputs integer Y.
// - Walk direction follows the sign of each delta.
// - Y values are sign, fifteen integer and sixteen fraction bits.
// - X walker: start, step constant, step variable or hold each clock.
// - Lower half subtracts left, adds right, address up; upper reverses.
// - Point count is diameter in sub-steps; flag flips halfway.
// - Subtraction complements the extended table value before the adder.
// - Table is 32 nibbles, 1.3 format, four words, entry 0 in bits 3:0.
`ifndef RSEW_CONSTS_SVH
`define RSEW_CONSTS_SVH
// Register indices on the plain register port.
`define RSEW_ADDR_W 5
`define RSEW_REG_PTAB0 5'h00
`define RSEW_REG_PTAB3 5'h03
`define RSEW_REG_YSTART 5'h04
`define RSEW_REG_DY 5'h05
`define RSEW_REG_LSTART 5'h06
`define RSEW_REG_DL 5'h07
`define RSEW_REG_TSTART 5'h08
`define RSEW_REG_DT 5'h09
`define RSEW_REG_COUNT 5'h0a
`define RSEW_REG_STATUS 5'h0b
`define RSEW_REG_CMD 5'h0c
// Command codes written to the command register.
`define RSEW_CMD_LINE 3'h1
`define RSEW_CMD_TRAP 3'h2
`define RSEW_CMD_POINT 3'h3
`define RSEW_CMD_CONT 3'h4
`define RSEW_CMD_FLUSH 3'h5
// Command register fields: bits 2:0 code, bit 3 antialias enable.
`define RSEW_CMD_AA_BIT 3
// Fixed point layout.
`define RSEW_FRAC_W 16
`define RSEW_SUB_ROWS 3'h4
`define RSEW_FULL_COV 3'h4
`define RSEW_ZERO_32 32'h0000_0000
`endif

// >>> rtl/rsew_pkg.sv
// Types for the rasteriser edge walker.
// Assumes the constants header sits beside it in rtl/.
`include "rsew_consts.svh"
package rsew_pkg;
  typedef enum logic [2:0] {
    MSG_DIAG_ACTIVE, MSG_ACTIVE_ACROSS, MSG_PASSIVE_ACROSS,
    MSG_ACTIVE_LEAD, MSG_PASSIVE_LEAD, MSG_COVERAGE
  } rsew_msg_type;
  typedef struct packed {
    logic valid;
    rsew_msg_type kind;
    logic [15:0] x;
    logic [15:0] y;
    logic [4:0] cov;
  } rsew_out_type;
  typedef enum logic [3:0] {
    ST_IDLE, ST_LINE, ST_SPAN_SETUP, ST_SPAN_WALK, ST_AA_LOAD,
    ST_AA_FILL, ST_AA_COV, ST_POINT
  } rsew_state_type;
  typedef struct packed {
    logic [1:0] lo;
    logic [1:0] hi;
  } rsew_pair_type;
endpackage : rsew_pkg

// >>> rtl/rsew_edge_walker.sv
// Rasteriser edge walker: Y and X edge walkers, point offset table,
// aliased and antialiased span fill, and step/coverage message output.
// Assumes the downstream consumer accepts one message per clock and that
// the host loads start, delta and count before each command.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "rsew_consts.svh"
module rsew_edge_walker #(
  parameter int SUBS = 4
) (
  input wire logic ref_clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [4:0] reg_addr, // Register index.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, one cycle after strobe.
  output rsew_pkg::rsew_out_type msg_out, // Step and coverage messages.
  output logic busy // Walker is running a primitive.
);
  typedef struct packed {
    rsew_pkg::rsew_state_type st;
    logic [127:0] ptab;
    logic [31:0] y_start, dy, l_start, dl, t_start, dt;
    logic [31:0] y, xl, xt;
    logic [15:0] count;
    logic aa;
    logic point;
    logic [2:0] sub;
    logic [3:0][31:0] slead;
    logic [3:0][31:0] strail;
    logic [31:0] xcnt, xstop;
    logic rtl_dir;
    logic dir_known;
    logic [4:0] paddr;
    logic upper;
    logic [15:0] half;
    logic [4:0] cov;
    logic [31:0] rdata;
    logic busy;
    rsew_pkg::rsew_out_type out;
  } rsew_walk_state_type;
  rsew_walk_state_type s_r, s_nxt;

  // Integer pixel part of a 16.16 coordinate.
  function automatic logic [15:0] ipart(input logic [31:0] v);
    ipart = v[31:16];
  endfunction : ipart

  // Sub-pixel quarter position, 0..3, from the fraction.
  function automatic logic [2:0] quart(input logic [31:0] v);
    quart = {1'b0, v[15:14]};
  endfunction : quart

  // Coverage of pixel px by one sub-row, in quarters.
  function automatic logic [2:0] subcov(input logic [31:0] ld,
                                        input logic [31:0] tr,
                                        input logic rtl,
                                        input logic [15:0] px);
    logic [15:0] il;
    logic [15:0] it;
    logic [2:0] ql;
    logic [2:0] qt;
    il = ipart(ld);
    it = ipart(tr);
    ql = quart(ld);
    qt = quart(tr);
    subcov = 3'h0;
    if (!rtl) begin
      if ($signed(il) > $signed(px) || $signed(it) < $signed(px)) subcov = 3'h0;
      else if (il != px && it != px) subcov = `RSEW_FULL_COV;
      else if (il == px && it != px) subcov = `RSEW_FULL_COV - ql;
      else if (il != px) subcov = qt;
      else subcov = (qt > ql) ? qt - ql : ql - qt;
    end else begin
      if ($signed(il) < $signed(px) || $signed(it) > $signed(px)) subcov = 3'h0;
      else if (il != px && it != px) subcov = `RSEW_FULL_COV;
      else if (il == px && it != px) subcov = ql;
      else if (il != px) subcov = `RSEW_FULL_COV - qt;
      else subcov = (qt > ql) ? qt - ql : ql - qt;
    end
  endfunction : subcov

  // Point delta, zero extended from 1.3 to 16.16 and complemented on subtract.
  function automatic logic [31:0] pdelta(input logic [3:0] nib,
                                         input logic sub);
    logic [31:0] e;
    e = {15'h0000, nib, 13'h0000};
    pdelta = sub ? ~e + 32'h0000_0001 : e;
  endfunction : pdelta

  // Emit one output message.
  function automatic rsew_pkg::rsew_out_type msg(input rsew_pkg::rsew_msg_type k,
                                                 input logic [15:0] x,
                                                 input logic [15:0] y,
                                                 input logic [4:0] c);
    msg = '{valid: 1'b1, kind: k, x: x, y: y, cov: c};
  endfunction : msg

  logic [4:0] cov_sum;
  always_comb begin
    cov_sum = 5'h00;
    for (int i = 0; i < SUBS; i++) begin
      if (3'(i) < s_r.sub)
        cov_sum = cov_sum + {2'b00, subcov(s_r.slead[i], s_r.strail[i],
                                           s_r.rtl_dir, ipart(s_r.xcnt))};
    end
  end

  logic [3:0] nib;
  assign nib = s_r.ptab[{s_r.paddr, 2'b00} +: 4];

  always_comb begin
    s_nxt = s_r;
    s_nxt.out = '0;
    s_nxt.rdata = `RSEW_ZERO_32;
    // ============================================================
    // Register port.
    if (reg_rd) begin
      if (reg_addr <= `RSEW_REG_PTAB3)
        s_nxt.rdata = s_r.ptab[{reg_addr[1:0], 5'h00} +: 32];
      else if (reg_addr == `RSEW_REG_STATUS)
        s_nxt.rdata = {12'h000, s_r.count, 3'h0, (s_r.st != rsew_pkg::ST_IDLE)};
      else if (reg_addr == `RSEW_REG_COUNT)
        s_nxt.rdata = {16'h0000, s_r.count};
    end
    if (reg_wr) begin
      unique case (reg_addr)
        5'h00, 5'h01, 5'h02, `RSEW_REG_PTAB3:
          s_nxt.ptab[{reg_addr[1:0], 5'h00} +: 32] = reg_wdata;
        `RSEW_REG_YSTART: s_nxt.y_start = reg_wdata;
        `RSEW_REG_DY: s_nxt.dy = reg_wdata;
        `RSEW_REG_LSTART: s_nxt.l_start = reg_wdata;
        `RSEW_REG_DL: s_nxt.dl = reg_wdata;
        `RSEW_REG_TSTART: s_nxt.t_start = reg_wdata;
        `RSEW_REG_DT: s_nxt.dt = reg_wdata;
        `RSEW_REG_COUNT: s_nxt.count = reg_wdata[15:0];
        default: ;
      endcase
    end
    // ============================================================
    // Sequencer.
    unique case (s_r.st)
      rsew_pkg::ST_IDLE: begin
        if (reg_wr && reg_addr == `RSEW_REG_CMD) begin
          unique case (reg_wdata[2:0])
            `RSEW_CMD_LINE: begin
              s_nxt.y = s_r.y_start;
              s_nxt.xl = s_r.l_start;
              s_nxt.st = rsew_pkg::ST_LINE;
            end
            `RSEW_CMD_TRAP: begin
              // Continue and flush resume in the mode chosen here.
              s_nxt.aa = reg_wdata[`RSEW_CMD_AA_BIT];
              s_nxt.y = s_r.y_start;
              s_nxt.xl = s_r.l_start;
              s_nxt.xt = s_r.t_start;
              s_nxt.sub = 3'h0;
              s_nxt.st = reg_wdata[`RSEW_CMD_AA_BIT] ? rsew_pkg::ST_AA_LOAD
                                                      : rsew_pkg::ST_SPAN_SETUP;
            end
            `RSEW_CMD_CONT: begin
              s_nxt.xt = s_r.t_start;
              s_nxt.st = s_r.aa ? rsew_pkg::ST_AA_LOAD
                                : rsew_pkg::ST_SPAN_SETUP;
            end
            `RSEW_CMD_FLUSH: begin
              if (s_r.sub != 3'h0) begin
                s_nxt.xcnt = s_r.rtl_dir ? s_r.xcnt : s_r.xcnt;
                s_nxt.st = rsew_pkg::ST_AA_FILL;
              end
            end
            `RSEW_CMD_POINT: begin
              s_nxt.y = s_r.y_start;
              s_nxt.xl = s_r.l_start;
              s_nxt.xt = s_r.l_start;
              s_nxt.paddr = 5'h00;
              s_nxt.upper = 1'b0;
              s_nxt.half = {1'b0, s_r.count[15:1]};
              s_nxt.point = 1'b1;
              s_nxt.sub = 3'h0;
              s_nxt.st = rsew_pkg::ST_POINT;
            end
            default: ;
          endcase
        end
      end
      rsew_pkg::ST_LINE: begin
        if (s_r.count == 16'h0000) s_nxt.st = rsew_pkg::ST_IDLE;
        else begin
          s_nxt.out = msg(rsew_pkg::MSG_DIAG_ACTIVE, ipart(s_r.xl),
                          ipart(s_r.y), 5'h00);
          s_nxt.xl = s_r.xl + s_r.dl;
          s_nxt.y = s_r.y + s_r.dy;
          s_nxt.count = s_r.count - 16'h0001;
        end
      end
      rsew_pkg::ST_SPAN_SETUP: begin
        if (s_r.count == 16'h0000) s_nxt.st = rsew_pkg::ST_IDLE;
        else begin
          s_nxt.xcnt = s_r.xl;
          s_nxt.xstop = s_r.xt;
          s_nxt.rtl_dir = $signed(ipart(s_r.xl)) > $signed(ipart(s_r.xt));
          s_nxt.dir_known = 1'b0;
          s_nxt.st = rsew_pkg::ST_SPAN_WALK;
        end
      end
      rsew_pkg::ST_SPAN_WALK: begin
        // One message per clock meets the two-cycle fragment budget.
        if (ipart(s_r.xcnt) == ipart(s_r.xstop)) begin
          s_nxt.out = msg(s_r.rtl_dir && s_r.dir_known ?
                          rsew_pkg::MSG_ACTIVE_LEAD : rsew_pkg::MSG_PASSIVE_LEAD,
                          ipart(s_r.xcnt), ipart(s_r.y), 5'h00);
          s_nxt.y = s_r.y + s_r.dy;
          s_nxt.xl = s_r.xl + s_r.dl;
          s_nxt.xt = s_r.xt + s_r.dt;
          s_nxt.count = s_r.count - 16'h0001;
          s_nxt.st = rsew_pkg::ST_SPAN_SETUP;
        end else begin
          s_nxt.out = msg((s_r.rtl_dir && !s_r.dir_known) ?
                          rsew_pkg::MSG_PASSIVE_ACROSS : rsew_pkg::MSG_ACTIVE_ACROSS,
                          ipart(s_r.xcnt), ipart(s_r.y), 5'h00);
          s_nxt.dir_known = 1'b1;
          s_nxt.xcnt = s_r.rtl_dir ? s_r.xcnt - 32'h0001_0000
                                   : s_r.xcnt + 32'h0001_0000;
        end
      end
      rsew_pkg::ST_AA_LOAD: begin
        if (s_r.sub == `RSEW_SUB_ROWS) begin
          s_nxt.xcnt = s_r.xcnt;
          s_nxt.st = rsew_pkg::ST_AA_FILL;
        end else if (s_r.count == 16'h0000) begin
          s_nxt.st = rsew_pkg::ST_IDLE;
        end else begin
          s_nxt.slead[s_r.sub[1:0]] = s_r.xl;
          s_nxt.strail[s_r.sub[1:0]] = s_r.xt;
          if (s_r.sub == 3'h0 || !s_r.dir_known) begin
            s_nxt.xcnt = s_r.xl;
            s_nxt.xstop = s_r.xt;
            s_nxt.rtl_dir = $signed(s_r.xl) >= $signed(s_r.xt);
            s_nxt.dir_known = s_r.xl != s_r.xt;
          end else if (!s_r.rtl_dir) begin
            if ($signed(s_r.xl) < $signed(s_r.xcnt)) s_nxt.xcnt = s_r.xl;
            if ($signed(s_r.xt) > $signed(s_r.xstop)) s_nxt.xstop = s_r.xt;
          end else begin
            if ($signed(s_r.xl) > $signed(s_r.xcnt)) s_nxt.xcnt = s_r.xl;
            if ($signed(s_r.xt) < $signed(s_r.xstop)) s_nxt.xstop = s_r.xt;
          end
          s_nxt.xl = s_r.xl + s_r.dl;
          s_nxt.xt = s_r.xt + s_r.dt;
          s_nxt.count = s_r.count - 16'h0001;
          s_nxt.sub = s_r.sub + 3'h1;
        end
      end
      rsew_pkg::ST_AA_FILL: begin
        s_nxt.cov = cov_sum;
        if (cov_sum == 5'h00) begin
          if (ipart(s_r.xcnt) == ipart(s_r.xstop)) begin
            s_nxt.out = msg(rsew_pkg::MSG_PASSIVE_LEAD, ipart(s_r.xcnt),
                            ipart(s_r.y), 5'h00);
            s_nxt.y = s_r.y + s_r.dy;
            s_nxt.sub = 3'h0;
            s_nxt.st = rsew_pkg::ST_AA_LOAD;
          end else begin
            s_nxt.out = msg(rsew_pkg::MSG_PASSIVE_ACROSS, ipart(s_r.xcnt),
                            ipart(s_r.y), 5'h00);
            s_nxt.xcnt = s_r.rtl_dir ? s_r.xcnt - 32'h0001_0000
                                     : s_r.xcnt + 32'h0001_0000;
          end
        end else begin
          s_nxt.out = msg(ipart(s_r.xcnt) == ipart(s_r.xstop) ?
                          rsew_pkg::MSG_ACTIVE_LEAD : rsew_pkg::MSG_ACTIVE_ACROSS,
                          ipart(s_r.xcnt), ipart(s_r.y), 5'h00);
          s_nxt.st = rsew_pkg::ST_AA_COV;
        end
      end
      rsew_pkg::ST_AA_COV: begin
        s_nxt.out = msg(rsew_pkg::MSG_COVERAGE, ipart(s_r.xcnt),
                        ipart(s_r.y), s_r.cov);
        if (ipart(s_r.xcnt) == ipart(s_r.xstop)) begin
          s_nxt.y = s_r.y + s_r.dy;
          s_nxt.sub = 3'h0;
          s_nxt.st = rsew_pkg::ST_AA_LOAD;
        end else begin
          s_nxt.xcnt = s_r.rtl_dir ? s_r.xcnt - 32'h0001_0000
                                   : s_r.xcnt + 32'h0001_0000;
          s_nxt.st = rsew_pkg::ST_AA_FILL;
        end
      end
      rsew_pkg::ST_POINT: begin
        if (s_r.count == 16'h0000) begin
          s_nxt.point = 1'b0;
          s_nxt.st = rsew_pkg::ST_IDLE;
        end else begin
          // Step variable on both X walkers from the offset table.
          s_nxt.xl = s_r.xl + pdelta(nib, !s_r.upper);
          s_nxt.xt = s_r.xt + pdelta(nib, s_r.upper);
          s_nxt.out = msg(rsew_pkg::MSG_PASSIVE_LEAD, ipart(s_r.xl),
                          ipart(s_r.y), 5'h00);
          s_nxt.count = s_r.count - 16'h0001;
          if (s_r.count - 16'h0001 == s_r.half && !s_r.upper)
            s_nxt.upper = 1'b1;
          else
            s_nxt.paddr = s_r.upper ? s_r.paddr - 5'h01 : s_r.paddr + 5'h01;
          s_nxt.y = s_r.y + s_r.dy;
        end
      end
      default: s_nxt.st = rsew_pkg::ST_IDLE;
    endcase
    s_nxt.busy = s_nxt.st != rsew_pkg::ST_IDLE;
  end

  // ============================================================
  // State register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) s_r <= '{st: rsew_pkg::ST_IDLE, default: '0};
    else s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign msg_out = s_r.out;
  assign busy = s_r.busy;
endmodule : rsew_edge_walker
`default_nettype wire

// >>> verification/rsew_edge_walker_monitor.sv
// Concurrent checks on the ports of the rasteriser edge walker.
// Assumes binding to rsew_edge_walker with one clock and async reset.
`timescale 1ns/100ps
`default_nettype none
`include "rsew_consts.svh"
module rsew_edge_walker_monitor #(
  parameter int SUBS = 4
) (
  input wire logic ref_clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [4:0] reg_addr, // Register index.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire rsew_pkg::rsew_out_type msg_out, // Output messages.
  input wire logic busy // Walker running.
);
  // ============================================================
  // Helpers
  wire logic act;
  wire logic cov;
  assign act = msg_out.valid && (msg_out.kind inside
    {rsew_pkg::MSG_ACTIVE_ACROSS, rsew_pkg::MSG_ACTIVE_LEAD});
  assign cov = msg_out.valid && msg_out.kind == rsew_pkg::MSG_COVERAGE;
  // Antialias mode of the primitive that a render command started.
  logic aa_mode_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) aa_mode_r <= 1'b0;
    else if (reg_wr && reg_addr == `RSEW_REG_CMD && !busy
             && reg_wdata[2:0] inside {`RSEW_CMD_LINE, `RSEW_CMD_TRAP,
                                       `RSEW_CMD_POINT})
      aa_mode_r <= reg_wdata[`RSEW_CMD_AA_BIT];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Assertions
  a_cov_follows: assert property (aa_mode_r && act |=> cov)
    else $error("coverage message missing after active step");
  a_alias_nocov: assert property (!aa_mode_r |-> !cov)
    else $error("coverage message in aliased mode");
  a_cov_cause: assert property (cov |-> $past(act))
    else $error("coverage message without active step");
  a_cov_range: assert property (cov |-> msg_out.cov != 5'h00 && msg_out.cov <= 5'h10)
    else $error("coverage value out of range");
  a_passive_nocov: assert property (msg_out.valid && !act && !cov |=> !cov)
    else $error("coverage after passive step");
  a_rate_kept: assert property (msg_out.valid
    && msg_out.kind == rsew_pkg::MSG_DIAG_ACTIVE |-> ##[1:2] (msg_out.valid || !busy))
    else $error("fragment rate too low");
  a_line_start: assert property (reg_wr && reg_addr == `RSEW_REG_CMD
    && reg_wdata[2:0] == `RSEW_CMD_LINE && !busy |=> busy)
    else $error("line command not taken");
  a_busy_cause: assert property ($rose(busy) |-> $past(reg_wr && reg_addr == `RSEW_REG_CMD))
    else $error("busy without command");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !msg_out.valid)
    else $error("message while idle");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : rsew_edge_walker_monitor
bind rsew_edge_walker rsew_edge_walker_monitor #(.SUBS(SUBS)) i_mon (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .msg_out(msg_out), .busy(busy));
`default_nettype wire

// >>> verification/rsew_msg_sink.sv
// Downstream pipeline model: logs every message it receives.
// Assumes one message per clock, no back pressure.
`timescale 1ns/100ps
`default_nettype none
module rsew_msg_sink (
  input wire logic ref_clk, // Core clock.
  input wire logic rst, // Reset, log is kept quiet meanwhile.
  input wire rsew_pkg::rsew_out_type msg_out // Messages from the walker.
);
  rsew_pkg::rsew_out_type q[$];
  // ============================================================
  // Message log
  always @(posedge ref_clk) begin
    if (rst === 1'b0 && msg_out.valid === 1'b1) begin
      q.push_back(msg_out);
    end
  end
endmodule : rsew_msg_sink
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the rasteriser edge walker.
// Assumes the design in rtl/ and the message sink model.
`timescale 1ns/100ps
`default_nettype none
`include "rsew_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %0t got %h want %h", $time, g, e); end end
module testbench;
  logic ref_clk, rst, reg_wr, reg_rd, busy;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  rsew_pkg::rsew_out_type msg_out;
  int fail_count = 0;
  int n_compared = 0;
  rsew_edge_walker i_rsew_edge_walker (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_out(msg_out), .busy(busy));
  rsew_msg_sink i_rsew_msg_sink (.ref_clk(ref_clk), .rst(rst),
    .msg_out(msg_out));
  // ============================================================
  // Bus and message tasks
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic go(input logic [3:0] c, input int n_exp);
    int n;
    i_rsew_msg_sink.q.delete();
    wr(`RSEW_REG_CMD, {28'h0, c});
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (busy !== 1'b0 && n < 300);
    if (n >= 300) begin
      fail_count++;
      $display("ERROR %0t walker stuck busy", $time);
    end
    repeat (3) @(posedge ref_clk);
    `CHK(i_rsew_msg_sink.q.size(), n_exp)
  endtask : go
  task automatic em(input int i, input rsew_pkg::rsew_msg_type k,
    input logic [15:0] x, input logic [15:0] y, input logic [4:0] c);
    rsew_pkg::rsew_out_type m;
    m = (i < i_rsew_msg_sink.q.size()) ? i_rsew_msg_sink.q[i] : '0;
    `CHK(m.valid, 1'b1)
    `CHK(m.kind, k)
    if (k inside {rsew_pkg::MSG_DIAG_ACTIVE, rsew_pkg::MSG_ACTIVE_ACROSS,
        rsew_pkg::MSG_ACTIVE_LEAD}) `CHK(m.x, x)
    if (k == rsew_pkg::MSG_DIAG_ACTIVE) `CHK(m.y, y)
    if (k == rsew_pkg::MSG_COVERAGE) `CHK(m.cov, c)
  endtask : em
  // ============================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 4; i++) wr(5'(i), 32'h0123_4567 + 32'(i));
    for (int i = 0; i < 4; i++) rd(5'(i), 32'h0123_4567 + 32'(i));
    rd(5'h1f, 32'h0000_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_1234);
    rd(`RSEW_REG_COUNT, 32'h0000_1234);
    rd(`RSEW_REG_STATUS, 32'h0001_2340);
  endtask : t_regs
  task automatic t_line;
    wr(`RSEW_REG_YSTART, 32'h0005_0000);
    wr(`RSEW_REG_DY, 32'h0001_0000);
    wr(`RSEW_REG_LSTART, 32'h000a_0000);
    wr(`RSEW_REG_DL, 32'hffff_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0003);
    go({1'b0, `RSEW_CMD_LINE}, 3);
    em(0, rsew_pkg::MSG_DIAG_ACTIVE, 16'h000a, 16'h0005, 5'h00);
    em(1, rsew_pkg::MSG_DIAG_ACTIVE, 16'h0009, 16'h0006, 5'h00);
    em(2, rsew_pkg::MSG_DIAG_ACTIVE, 16'h0008, 16'h0007, 5'h00);
  endtask : t_line
  task automatic t_trap;
    wr(`RSEW_REG_DL, 32'h0000_0000);
    wr(`RSEW_REG_DT, 32'h0000_0000);
    wr(`RSEW_REG_LSTART, 32'h0003_4000);
    wr(`RSEW_REG_TSTART, 32'h0003_c000);
    wr(`RSEW_REG_COUNT, 32'h0000_0001);
    go({1'b0, `RSEW_CMD_TRAP}, 1);
    em(0, rsew_pkg::MSG_PASSIVE_LEAD, 16'h0, 16'h0, 5'h00);
    wr(`RSEW_REG_LSTART, 32'h0002_0000);
    wr(`RSEW_REG_TSTART, 32'h0005_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0001);
    go({1'b0, `RSEW_CMD_TRAP}, 4);
    for (int i = 0; i < 3; i++)
      em(i, rsew_pkg::MSG_ACTIVE_ACROSS, 16'(2 + i), 16'h0, 5'h00);
    em(3, rsew_pkg::MSG_PASSIVE_LEAD, 16'h0, 16'h0, 5'h00);
    wr(`RSEW_REG_TSTART, 32'h0004_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0001);
    go({1'b0, `RSEW_CMD_CONT}, 3);
    em(0, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0002, 16'h0, 5'h00);
    em(1, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0003, 16'h0, 5'h00);
    em(2, rsew_pkg::MSG_PASSIVE_LEAD, 16'h0, 16'h0, 5'h00);
    wr(`RSEW_REG_LSTART, 32'h0005_0000);
    wr(`RSEW_REG_TSTART, 32'h0002_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0001);
    go({1'b0, `RSEW_CMD_TRAP}, 4);
    em(0, rsew_pkg::MSG_PASSIVE_ACROSS, 16'h0, 16'h0, 5'h00);
    em(1, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0004, 16'h0, 5'h00);
    em(2, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0003, 16'h0, 5'h00);
    em(3, rsew_pkg::MSG_ACTIVE_LEAD, 16'h0002, 16'h0, 5'h00);
  endtask : t_trap
  task automatic aa_span(input logic [4:0] c);
    em(0, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0002, 16'h0, 5'h00);
    em(1, rsew_pkg::MSG_COVERAGE, 16'h0, 16'h0, c);
    em(2, rsew_pkg::MSG_ACTIVE_ACROSS, 16'h0003, 16'h0, 5'h00);
    em(3, rsew_pkg::MSG_COVERAGE, 16'h0, 16'h0, c);
    em(4, rsew_pkg::MSG_PASSIVE_LEAD, 16'h0, 16'h0, 5'h00);
  endtask : aa_span
  task automatic t_aa;
    wr(`RSEW_REG_LSTART, 32'h0002_0000);
    wr(`RSEW_REG_TSTART, 32'h0004_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0004);
    go({1'b1, `RSEW_CMD_TRAP}, 5);
    aa_span(5'h10);
    wr(`RSEW_REG_COUNT, 32'h0000_0002);
    go({1'b1, `RSEW_CMD_TRAP}, 0);
    go({1'b0, `RSEW_CMD_FLUSH}, 5);
    aa_span(5'h08);
  endtask : t_aa
  task automatic t_point;
    logic [15:0] xs [6] = '{16'h000a, 16'h0009, 16'h0008, 16'h0008,
                            16'h0008, 16'h0009};
    wr(`RSEW_REG_PTAB0, 32'h0000_0048);
    wr(`RSEW_REG_LSTART, 32'h000a_0000);
    wr(`RSEW_REG_COUNT, 32'h0000_0006);
    go({1'b0, `RSEW_CMD_POINT}, 6);
    for (int i = 0; i < 6; i++) begin
      em(i, rsew_pkg::MSG_PASSIVE_LEAD, 16'h0, 16'h0, 5'h00);
      `CHK(i_rsew_msg_sink.q[i].x, xs[i])
    end
  endtask : t_point
  // ============================================================
  // Closing, clock, watchdog and main sequence
  task automatic results;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #(8 * 20000);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0000_0000;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_line();
    t_trap();
    t_aa();
    t_point();
    results();
  end
endmodule : testbench
`default_nettype wire
